// *** hdl/trigger_terminal_judge_pkg.sv ***
/*
 * Shared constants and types for the trigger, compensation and limit judge block.
 * Assumes a 20 MHz system clock and a 32-bit Avalon-MM register port.
 */
package trigger_terminal_judge_pkg;

    // clock and documented times
    localparam int unsigned CLK_HZ = 32'd20_000_000;
    localparam int unsigned COMP_TIME_S = 32'd30;
    localparam int unsigned OFF_HOLD_TIME_S = 32'd2;
    localparam int unsigned FLASH_TIME_MS = 32'd250;
    localparam int unsigned COMP_CYCLES_DFLT = COMP_TIME_S * CLK_HZ;
    localparam int unsigned OFF_HOLD_CYCLES_DFLT = OFF_HOLD_TIME_S * CLK_HZ;
    localparam int unsigned FLASH_CYCLES_DFLT = FLASH_TIME_MS * (CLK_HZ / 32'd1000);

    // register byte offsets
    localparam logic [5:0] CTRL_OFF = 6'h00;
    localparam logic [5:0] CMD_OFF = 6'h04;
    localparam logic [5:0] EDIT_OFF = 6'h08;
    localparam logic [5:0] STATUS_OFF = 6'h0c;
    localparam logic [5:0] LIMIT_BASE_OFF = 6'h10;

    // ctrl fields
    localparam int CTRL_OUTSIDE_BIT = 0;
    localparam int CTRL_HOLD_BIT = 1;

    // command bits, write one to fire
    localparam int CMD_IFACE_TRIGGER_TERMINAL_BIT = 0;
    localparam int CMD_ENTER_LIMITS_BIT = 1;
    localparam int CMD_ACK_BIT = 2;
    localparam int CMD_SHORT_START_BIT = 3;
    localparam int CMD_SHORT_CANCEL_BIT = 4;
    localparam int CMD_LEAVE_BIT = 5;
    localparam int CMD_WIDTH = 6;

    // edit and limit word fields
    localparam int LIMIT_OFF_BIT = 16;

    typedef enum logic [2:0] {
        plain_test_state,
        first_upper_entry,
        first_lower_entry,
        second_upper_entry,
        second_lower_entry,
        comparator_state,
        short_comp_state,
        comp_error_state
    } mode_t;

    typedef enum logic [1:0] {
        judge_none,
        judge_above,
        judge_within,
        judge_below
    } judge_t;

    typedef struct packed {
        logic off;
        logic [15:0] value;
    } limit_t;

    typedef struct packed {
        logic [15:0] value;
        logic over;
        logic under;
    } meas_t;

    typedef struct packed {
        logic first_above;
        logic first_within;
        logic first_below;
        logic second_above;
        logic second_within;
        logic second_below;
        logic both_within;
    } rear_io_t;

    typedef struct packed {
        mode_t state;
        logic waitrequest;
        logic [31:0] rdata;
        logic outside_trigger_mode;
        logic user_hold;
        logic busy;
        logic start;
        logic pend;
        logic trigger_terminal_prev;
        logic key_prev;
        limit_t [3:0] lim;
        limit_t edit;
        logic [29:0] hold_cnt;
        logic [29:0] comp_cnt;
        logic [29:0] flash_cnt;
        logic lamp;
        logic comp_valid;
        logic comp_err;
        logic beep;
        logic started;
        logic range_hold;
        logic cmp_mode;
        judge_t j1;
        judge_t j2;
        rear_io_t io;
    } st_t;

    localparam limit_t LIMIT_RESET = '{off: 1'b1, value: 16'h0000};
    localparam st_t ST_RESET = '{state: plain_test_state, waitrequest: 1'b1,
                                 lim: {4{LIMIT_RESET}}, edit: LIMIT_RESET,
                                 j1: judge_none, j2: judge_none, default: '0};

endpackage

// *** hdl/measure_trigger_limit_judge.sv ***
/*
 * Trigger selection, short-circuit compensation sequencing, limit entry and
 * two-parameter limit judgment with a combined result on the rear connector.
 * Assumes the measurement engine answers each meas_start with one meas_done
 * pulse carrying both results, and that all inputs are synchronous to clk.
 */
// Functional notes
// R1: internal mode restarts a measurement as soon as the previous one finishes.
// R2: outside mode does one measurement per low-going pulse on the trigger terminal.
// R3: outside mode does one measurement per interface trigger command.
// R4: outside mode does one measurement per manual trigger key press.
// R5: each parameter is judged above, within or below.
// R6: combined output is true only when both parameters are within.
// R7: overflow judges above, underflow judges below, before any comparison.
// R8: value not greater than lower limit judges below, checked first.
// R9: value not less than upper limit judges above.
// R10: within only when both limit checks pass.
// R11: off limits are skipped; both off gives no judgment.
// R12: stored limits are not range or order checked.
// R13: limits are raw display counts, independent of test conditions.
// R14: limit entry and comparator operation force held ranging.
// R15: entry order is first upper, first lower, second upper, second lower.
// R16: after entry go to plain test if all off, else comparator.
// R17: power loss in comparator mode restarts in comparator mode.
// R18: power loss during entry discards the edited limit.
// R19: two-second end-of-cursor hold replaces the limit with off.
// R20: lamp flashes during compensation; success beeps once, returns to plain.
// R21: terminal impedance too high aborts compensation with beep and error.
// R22: cancelling compensation discards data until a fresh run completes.
// R23: every limit carries a separate off flag beside its count.
`timescale 1ns/100ps
`default_nettype none

module measure_trigger_limit_judge
    import trigger_terminal_judge_pkg::*;
#(
    parameter int unsigned COMP_CYCLES = COMP_CYCLES_DFLT,
    parameter int unsigned OFF_HOLD_CYCLES = OFF_HOLD_CYCLES_DFLT,
    parameter int unsigned FLASH_CYCLES = FLASH_CYCLES_DFLT
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic trigger_terminal_n,
    input wire logic manual_trigger_terminal_key,
    input wire logic digit_end_hold,
    input wire logic power_fail,
    input wire logic nv_comp_mode,
    input wire logic terminal_over_limit,
    output logic meas_start,
    input wire logic meas_done,
    input wire meas_t first_meas,
    input wire meas_t second_meas,
    output rear_io_t rear_io_connector,
    output logic range_hold,
    output logic comp_lamp,
    output logic comp_valid,
    output logic comp_error,
    output logic beep,
    output logic comparator_mode
);

    st_t s_r;
    st_t s_nxt;
    logic acc_wr;
    logic [CMD_WIDTH-1:0] cmd;
    logic trigger_terminal_ev;
    logic meas_ok;

    // limits are compared as raw counts, with no range or ordering check on store
    function automatic judge_t judge(input meas_t m, input limit_t up, input limit_t lo);
        judge_t j;
        // R10: within unless a check fails
        j = judge_within;
        // R11: off limits skipped
        if (up.off && lo.off) begin
            j = judge_none;
        // R7: range flags first
        end else if (m.over) begin
            j = judge_above;
        end else if (m.under) begin
            j = judge_below;
        // R8: lower check first
        end else if (!lo.off && !(m.value > lo.value)) begin
            j = judge_below;
        // R9: upper check second
        end else if (!up.off && !(m.value < up.value)) begin
            j = judge_above;
        end
        return j;
    endfunction

    function automatic logic [1:0] entry_idx(input mode_t m);
        logic [1:0] i;
        case (m)
            first_lower_entry: i = 2'h1;
            second_upper_entry: i = 2'h2;
            second_lower_entry: i = 2'h3;
            default: i = 2'h0;
        endcase
        return i;
    endfunction

    function automatic logic in_entry(input mode_t m);
        return (m == first_upper_entry) || (m == first_lower_entry) ||
               (m == second_upper_entry) || (m == second_lower_entry);
    endfunction

    assign acc_wr = write && !s_r.waitrequest;
    assign cmd = (acc_wr && address == CMD_OFF) ? writedata[CMD_WIDTH-1:0] : '0;
    assign meas_ok = (s_r.state == plain_test_state) || (s_r.state == comparator_state);
    // R2: falling edge of the terminal
    // R3: interface command
    // R4: key press edge
    assign trigger_terminal_ev = (!trigger_terminal_n && s_r.trigger_terminal_prev) || cmd[CMD_IFACE_TRIGGER_TERMINAL_BIT] ||
                     (manual_trigger_terminal_key && !s_r.key_prev);

    always_comb begin
        s_nxt = s_r;
        s_nxt.start = 1'b0;
        s_nxt.beep = 1'b0;
        s_nxt.trigger_terminal_prev = trigger_terminal_n;
        s_nxt.key_prev = manual_trigger_terminal_key;

        // one wait state, then the answer stands for the sampling edge
        if ((read || write) && s_r.waitrequest) begin
            s_nxt.waitrequest = 1'b0;
            s_nxt.rdata = '0;
            if (read) begin
                case (address)
                    CTRL_OFF: s_nxt.rdata = {30'h0, s_r.user_hold, s_r.outside_trigger_mode};
                    EDIT_OFF: s_nxt.rdata = {15'h0, s_r.edit};
                    STATUS_OFF: s_nxt.rdata = {20'h0, s_r.comp_valid, s_r.comp_err,
                                               s_r.busy, s_r.pend, s_r.j2, s_r.j1,
                                               s_r.range_hold, s_r.state};
                    6'h10, 6'h14, 6'h18, 6'h1c: s_nxt.rdata = {15'h0, s_r.lim[address[3:2]]};
                    default: s_nxt.rdata = '0;
                endcase
            end
        end else begin
            s_nxt.waitrequest = 1'b1;
        end
        if (acc_wr && address == CTRL_OFF) begin
            s_nxt.outside_trigger_mode = writedata[CTRL_OUTSIDE_BIT];
            s_nxt.user_hold = writedata[CTRL_HOLD_BIT];
        end

        // measurement launch; a fresh event in the launch cycle stays pending
        if (s_r.outside_trigger_mode && trigger_terminal_ev) begin
            s_nxt.pend = 1'b1;
        end
        if (!s_r.outside_trigger_mode) begin
            s_nxt.pend = 1'b0;
        end
        // R1: internal back to back
        if (!s_r.busy && s_r.started && meas_ok &&
            (!s_r.outside_trigger_mode || s_r.pend)) begin
            s_nxt.start = 1'b1;
            s_nxt.busy = 1'b1;
            s_nxt.pend = s_r.outside_trigger_mode && trigger_terminal_ev;
        end
        if (s_r.busy && meas_done) begin
            s_nxt.busy = 1'b0;
            if (s_r.state == comparator_state) begin
                // R5: per-parameter judgment
                s_nxt.j1 = judge(first_meas, s_r.lim[0], s_r.lim[1]);
                s_nxt.j2 = judge(second_meas, s_r.lim[2], s_r.lim[3]);
                s_nxt.io.first_above = (s_nxt.j1 == judge_above);
                s_nxt.io.first_within = (s_nxt.j1 == judge_within);
                s_nxt.io.first_below = (s_nxt.j1 == judge_below);
                s_nxt.io.second_above = (s_nxt.j2 == judge_above);
                s_nxt.io.second_within = (s_nxt.j2 == judge_within);
                s_nxt.io.second_below = (s_nxt.j2 == judge_below);
                // R6: combined result
                s_nxt.io.both_within = (s_nxt.j1 == judge_within) &&
                                       (s_nxt.j2 == judge_within);
            end
        end

        case (s_r.state)
            plain_test_state, comparator_state: begin
                if (cmd[CMD_ENTER_LIMITS_BIT]) begin
                    s_nxt.state = first_upper_entry;
                    s_nxt.edit = s_r.lim[0];
                    s_nxt.hold_cnt = '0;
                end else if (cmd[CMD_LEAVE_BIT]) begin
                    s_nxt.state = plain_test_state;
                end else if (s_r.state == plain_test_state && cmd[CMD_SHORT_START_BIT]) begin
                    s_nxt.state = short_comp_state;
                    s_nxt.comp_cnt = '0;
                    s_nxt.flash_cnt = '0;
                    s_nxt.comp_valid = 1'b0;
                    s_nxt.comp_err = 1'b0;
                end
            end
            first_upper_entry, first_lower_entry, second_upper_entry, second_lower_entry: begin
                if (acc_wr && address == EDIT_OFF) begin
                    // R12: stored with no check
                    // R13: raw display count
                    s_nxt.edit = '{off: 1'b0, value: writedata[15:0]};
                end
                // R19: long hold gives off
                if (digit_end_hold) begin
                    if (s_r.hold_cnt >= 30'(OFF_HOLD_CYCLES - 1)) begin
                        s_nxt.edit.off = 1'b1;
                    end else begin
                        s_nxt.hold_cnt = s_r.hold_cnt + 30'h1;
                    end
                end else begin
                    s_nxt.hold_cnt = '0;
                end
                // R18: drop the edit
                if (power_fail || cmd[CMD_LEAVE_BIT]) begin
                    s_nxt.state = plain_test_state;
                // R15: fixed entry order
                end else if (cmd[CMD_ACK_BIT]) begin
                    // R23: off flag stored beside count
                    s_nxt.lim[entry_idx(s_r.state)] = s_r.edit;
                    s_nxt.hold_cnt = '0;
                    case (s_r.state)
                        first_upper_entry: begin
                            s_nxt.state = first_lower_entry;
                            s_nxt.edit = s_r.lim[1];
                        end
                        first_lower_entry: begin
                            s_nxt.state = second_upper_entry;
                            s_nxt.edit = s_r.lim[2];
                        end
                        second_upper_entry: begin
                            s_nxt.state = second_lower_entry;
                            s_nxt.edit = s_r.lim[3];
                        end
                        // R16: all off returns to plain
                        default: begin
                            if (s_r.edit.off && s_r.lim[0].off && s_r.lim[1].off &&
                                s_r.lim[2].off) begin
                                s_nxt.state = plain_test_state;
                            end else begin
                                s_nxt.state = comparator_state;
                            end
                        end
                    endcase
                end
            end
            short_comp_state: begin
                s_nxt.comp_cnt = s_r.comp_cnt + 30'h1;
                // R21: abort on high impedance
                if (terminal_over_limit) begin
                    s_nxt.state = comp_error_state;
                    s_nxt.beep = 1'b1;
                    s_nxt.comp_err = 1'b1;
                    s_nxt.comp_valid = 1'b0;
                // R20: success beep and return; completion wins over a late cancel
                end else if (s_r.comp_cnt >= 30'(COMP_CYCLES - 1)) begin
                    s_nxt.state = plain_test_state;
                    s_nxt.beep = 1'b1;
                    s_nxt.comp_valid = 1'b1;
                // R22: cancel drops the run
                end else if (cmd[CMD_SHORT_CANCEL_BIT]) begin
                    s_nxt.state = plain_test_state;
                    s_nxt.comp_valid = 1'b0;
                end
            end
            comp_error_state: begin
                if (cmd[CMD_LEAVE_BIT]) begin
                    s_nxt.state = plain_test_state;
                    s_nxt.comp_err = 1'b0;
                end
            end
            default: s_nxt.state = plain_test_state;
        endcase

        // R22: cancel outside a run drops stored data
        if (cmd[CMD_SHORT_CANCEL_BIT] && s_r.state != short_comp_state) begin
            s_nxt.comp_valid = 1'b0;
        end

        // R17: restart in comparator mode
        if (!s_r.started) begin
            s_nxt.started = 1'b1;
            if (nv_comp_mode) begin
                s_nxt.state = comparator_state;
            end
        end

        // R20: lamp flashes while running
        if (s_nxt.state == short_comp_state) begin
            if (s_r.flash_cnt >= 30'(FLASH_CYCLES - 1)) begin
                s_nxt.flash_cnt = '0;
                s_nxt.lamp = !s_r.lamp;
            end else begin
                s_nxt.flash_cnt = s_r.flash_cnt + 30'h1;
            end
        end else begin
            s_nxt.lamp = s_nxt.comp_valid;
        end
        // judgments only stand while comparing
        if (s_nxt.state != comparator_state) begin
            s_nxt.io = '0;
            s_nxt.j1 = judge_none;
            s_nxt.j2 = judge_none;
        end
        // R14: forced held ranging
        s_nxt.range_hold = s_nxt.user_hold || in_entry(s_nxt.state) ||
                           (s_nxt.state == comparator_state);
        s_nxt.cmp_mode = (s_nxt.state == comparator_state);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_r <= ST_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign readdata = s_r.rdata;
    assign waitrequest = s_r.waitrequest;
    assign meas_start = s_r.start;
    assign rear_io_connector = s_r.io;
    assign range_hold = s_r.range_hold;
    assign comp_lamp = s_r.lamp;
    assign comp_valid = s_r.comp_valid;
    assign comp_error = s_r.comp_err;
    assign beep = s_r.beep;
    assign comparator_mode = s_r.cmp_mode;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    int_restart_a: assert property (!s_r.outside_trigger_mode && s_r.started && meas_ok && // R1
        !s_r.busy |=> meas_start) else $error("internal trigger did not restart");
    ext_quiet_a: assert property (s_r.outside_trigger_mode && !s_r.pend && !trigger_terminal_ev // R2
        |=> !meas_start) else $error("outside mode started with no trigger");
    iface_trigger_terminal_a: assert property (s_r.outside_trigger_mode && cmd[CMD_IFACE_TRIGGER_TERMINAL_BIT] // R3
        |=> s_r.pend) else $error("interface trigger lost");
    key_trigger_terminal_a: assert property (s_r.outside_trigger_mode && manual_trigger_terminal_key && // R4
        !s_r.key_prev |=> s_r.pend) else $error("key trigger lost");
    both_within_a: assert property (rear_io_connector.both_within == // R6
        (rear_io_connector.first_within && rear_io_connector.second_within))
        else $error("combined output disagrees");
    over_above_a: assert property (s_r.state == comparator_state && s_r.busy && meas_done && // R7
        first_meas.over && !(s_r.lim[0].off && s_r.lim[1].off) && !nv_comp_mode
        |=> ##0 (s_r.started && s_r.state != comparator_state) || rear_io_connector.first_above)
        else $error("overflow not judged above");
    lower_first_a: assert property (s_r.state == comparator_state && s_r.busy && meas_done && // R8
        !first_meas.over && !first_meas.under && !s_r.lim[1].off &&
        first_meas.value <= s_r.lim[1].value && !cmd[CMD_ENTER_LIMITS_BIT] &&
        !cmd[CMD_LEAVE_BIT] |=> rear_io_connector.first_below)
        else $error("low value not judged below");
    off_none_a: assert property (s_r.lim[0].off && s_r.lim[1].off |-> // R11
        !rear_io_connector.first_above && !rear_io_connector.first_within &&
        !rear_io_connector.first_below) else $error("judgment with both limits off");
    held_range_a: assert property (comparator_mode |-> range_hold) // R14
        else $error("comparator without held range");
    entry_order_a: assert property (s_r.state == first_upper_entry && cmd[CMD_ACK_BIT] && // R15
        !power_fail && !cmd[CMD_LEAVE_BIT] |=> s_r.state == first_lower_entry &&
        s_r.lim[0] == $past(s_r.edit)) else $error("entry order broken");
    comp_abort_a: assert property (s_r.state == short_comp_state && terminal_over_limit // R21
        |=> beep && comp_error && !comp_valid ##1 !beep)
        else $error("compensation abort wrong");
    cancel_comp_a: assert property (cmd[CMD_SHORT_CANCEL_BIT] && // R22
        !(s_r.state == short_comp_state && s_r.comp_cnt >= 30'(COMP_CYCLES - 1))
        |=> !comp_valid) else $error("cancel kept compensation");

    both_in_c: cover property (rear_io_connector.both_within);
    comp_done_c: cover property (s_r.state == short_comp_state ##1 comp_valid && beep);
    off_marker_c: cover property (in_entry(s_r.state) && s_r.edit.off && cmd[CMD_ACK_BIT]);
    ext_pulse_c: cover property (s_r.outside_trigger_mode && !trigger_terminal_n &&
        s_r.trigger_terminal_prev ##[1:4] meas_start);

endmodule

`default_nettype wire

// *** test/meas_partner.sv ***
/*
 * Far-side model: rear trigger source plus measurement engine answering.
 * Assumes one clock shared with the block and an active high async reset.
 */
`timescale 1ns/100ps
`default_nettype none
module meas_partner (
    input wire logic clk,
    input wire logic reset,
    input wire logic meas_start,
    input wire logic fire,
    input wire logic slow,
    output logic meas_done,
    output logic trigger_terminal_n
);
    int cnt;
    logic [1:0] pl;
    assign trigger_terminal_n = (pl == 2'h0);
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt <= 0;
            pl <= 2'h0;
            meas_done <= 1'b0;
        end else begin
            meas_done <= 1'b0;
            // slow answers let a trigger land while a measurement is busy
            if (meas_start) cnt <= slow ? 7 : 1;
            else if (cnt > 1) cnt <= cnt - 1;
            else if (cnt == 1) begin
                cnt <= 0;
                meas_done <= 1'b1;
            end
            if (fire) pl <= 2'h2;
            else if (pl != 2'h0) pl <= pl - 2'h1;
        end
    end
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
/*
 * Self-checking bench: Avalon master, trigger sources, result queues.
 * Assumes the block with shortened counts and the partner model.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top import trigger_terminal_judge_pkg::*;;
    logic clk = 0, reset = 1, read = 0, write = 0, key = 0, hold = 0, pf = 0, nv = 0;
    logic tol = 0, fire = 0, slow = 0, dd = 0, lp = 0;
    logic [5:0] addr = 6'h00;
    logic [31:0] wd = 32'h0, rdat;
    meas_t m1 = '0, m2 = '0, a, b;
    wire logic wr_w, ms, md, tn, rh, lamp, cv, ce, bp, cm;
    rear_io_t rio;
    int num_errors = 0, checks_done = 0, dones = 0, starts = 0, beeps = 0, tog = 0, d0;
    logic [63:0] rq[$];
    logic [63:0] q;
    rear_io_t iq[$];
    limit_t lm[4] = '{'{1'b0, 16'h8000}, '{1'b0, 16'h1000}, '{1'b0, 16'h4000}, '{1'b1, 16'h0}};
    logic [15:0] tbl[4] = '{16'h1000, 16'h1001, 16'h8000, 16'h7fff};
    measure_trigger_limit_judge #(.COMP_CYCLES(50), .OFF_HOLD_CYCLES(10), .FLASH_CYCLES(4)) dut_u (
        .clk(clk), .reset(reset), .address(addr), .read(read), .write(write),
        .writedata(wd), .readdata(rdat), .waitrequest(wr_w), .trigger_terminal_n(tn),
        .manual_trigger_terminal_key(key), .digit_end_hold(hold), .power_fail(pf), .nv_comp_mode(nv),
        .terminal_over_limit(tol), .meas_start(ms), .meas_done(md), .first_meas(m1),
        .second_meas(m2), .rear_io_connector(rio), .range_hold(rh), .comp_lamp(lamp),
        .comp_valid(cv), .comp_error(ce), .beep(bp), .comparator_mode(cm));
    meas_partner part_u (.clk(clk), .reset(reset), .meas_start(ms), .fire(fire), .slow(slow),
        .meas_done(md), .trigger_terminal_n(tn));
    initial forever #25 clk = ~clk;
    task automatic cmp(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
        checks_done++;
        if ((g & m) !== (e & m)) begin
            num_errors++;
            $display("CHECK FAILED %0t value %h expected %h", $time, g, e);
        end
    endtask
    task automatic cio(input rear_io_t g, input rear_io_t e);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %0t rear %b expected %b", $time, g, e);
        end
    endtask
    function automatic logic [2:0] jd(meas_t m, limit_t u, limit_t l);
        if (u.off && l.off) return 3'b000;
        if (m.over) return 3'b100;
        if (m.under) return 3'b001;
        if (!l.off && !(m.value > l.value)) return 3'b001;
        if (!u.off && !(m.value < u.value)) return 3'b100;
        return 3'b010;
    endfunction
    task automatic bus(input logic r, input logic [5:0] ad, input logic [31:0] d);
        @(posedge clk);
        read <= r;
        write <= !r;
        addr <= ad;
        wd <= d;
        do begin
            @(posedge clk);
        end while (wr_w !== 1'b0);
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] ad, input logic [31:0] e, input logic [31:0] m);
        rq.push_back({m, e});
        bus(1'b1, ad, 32'h0);
    endtask
    task automatic msr(input int k);
        logic [2:0] x, y;
        x = jd(a, lm[0], lm[1]);
        y = jd(b, lm[2], lm[3]);
        iq.push_back({x, y, x[1] & y[1]});
        @(posedge clk);
        m1 <= a;
        m2 <= b;
        if (k % 3 == 1) bus(1'b0, CMD_OFF, 32'h1);
        else begin
            if (k % 3 == 0) fire <= 1'b1;
            else key <= 1'b1;
            @(posedge clk);
            fire <= 1'b0;
            key <= 1'b0;
        end
        do begin
            @(posedge clk);
        end while (md !== 1'b1);
        repeat (3) @(posedge clk);
    endtask
    task automatic print_verdict();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // results are taken off the queues as they appear
    always @(posedge clk) begin
        if (dd && iq.size() > 0) cio(rio, iq.pop_front());
        if (read && wr_w === 1'b0 && rq.size() > 0) begin
            q = rq.pop_front();
            cmp(rdat, q[31:0], q[63:32]);
        end
        dd <= md;
        lp <= lamp;
        dones += (md === 1'b1);
        starts += (ms === 1'b1);
        beeps += (bp === 1'b1);
        tog += (lamp !== lp);
    end
    initial begin
        #(50 * 20000);
        num_errors++;
        print_verdict();
    end
    initial begin
        void'($urandom(92));
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        rd(STATUS_OFF, 32'h0, 32'hfff);
        rd(LIMIT_BASE_OFF, 32'h10000, '1);
        rd(6'h20, 32'h0, '1);
        repeat (40) @(posedge clk);
        cmp(starts >= 3, 1, 1);
        cmp({rh, cm}, 0, 3);
        bus(1'b0, CTRL_OFF, 32'h1);
        repeat (20) @(posedge clk);
        bus(1'b0, CMD_OFF, 32'h2);
        rd(STATUS_OFF, 32'h8, 32'h8);
        cmp(rh, 1, 1);
        for (int i = 0; i < 4; i++) begin
            rd(STATUS_OFF, i + 1, 32'h7);
            bus(1'b0, EDIT_OFF, {16'h0, lm[i].value});
            if (i == 3) begin
                // a written value clears off first, so only the long hold can set it
                hold <= 1'b1;
                repeat (15) @(posedge clk);
                hold <= 1'b0;
            end
            bus(1'b0, CMD_OFF, 32'h4);
        end
        rd(STATUS_OFF, 32'h5, 32'h7);
        for (int i = 0; i < 4; i++) rd(LIMIT_BASE_OFF + 4 * i, lm[i], i < 3 ? '1 : 32'h10000);
        d0 = dones;
        for (int k = 0; k < 12; k++) begin
            a = '{k < 4 ? tbl[k] : 16'($urandom), k == 4, k == 5};
            b = '{k == 6 ? 16'h4000 : 16'($urandom), k == 7, k == 8};
            slow <= k[0];
            msr(k);
        end
        cmp(dones - d0, 12, '1);
        bus(1'b0, CMD_OFF, 32'h2);
        bus(1'b0, EDIT_OFF, 32'h1234);
        pf <= 1'b1;
        @(posedge clk);
        pf <= 1'b0;
        rd(LIMIT_BASE_OFF, 32'h8000, '1);
        bus(1'b0, CMD_OFF, 32'h20);
        bus(1'b0, CMD_OFF, 32'h8);
        rd(STATUS_OFF, 32'h6, 32'h7);
        d0 = beeps;
        repeat (60) @(posedge clk);
        cmp(tog >= 6, 1, 1);
        cmp(cv, 1, 1);
        cmp(beeps - d0, 1, '1);
        rd(STATUS_OFF, 32'h0, 32'h7);
        bus(1'b0, CMD_OFF, 32'h10);
        @(posedge clk);
        cmp(cv, 0, 1);
        bus(1'b0, CMD_OFF, 32'h8);
        bus(1'b0, CMD_OFF, 32'h10);
        rd(STATUS_OFF, 32'h0, 32'h7);
        bus(1'b0, CMD_OFF, 32'h8);
        tol <= 1'b1;
        repeat (3) @(posedge clk);
        tol <= 1'b0;
        cmp(ce, 1, 1);
        rd(STATUS_OFF, 32'h7, 32'h7);
        bus(1'b0, CMD_OFF, 32'h20);
        cmp(cv, 0, 1);
        bus(1'b0, CTRL_OFF, 32'h3);
        rd(CTRL_OFF, 32'h3, '1);
        cmp(rh, 1, 1);
        nv <= 1'b1;
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        cmp(cm, 1, 1);
        repeat (12) @(posedge clk);
        cio(rio, '0);
        print_verdict();
    end
endmodule
`default_nettype wire
